// [evpr_pkg.sv]
// Constants and types for the event poll responder.
// Assumes a 16-bit master frame word and a plain register port.
package evpr_pkg;
	localparam int          EVPR_FW       = 16;
	localparam int          EVPR_AW       = 12;
	localparam logic [3:0]  EVPR_FC_START = 4'h9;
	localparam logic [3:0]  EVPR_FC_GROUP = 4'hd;
	localparam logic [3:0]  EVPR_FC_INDIV = 4'he;
	localparam int          EVPR_FC_LSB   = 12;
	localparam int          EVPR_EM_LSB   = 8;
	localparam int          EVPR_ET_LSB   = 4;
	localparam logic [3:0]  EVPR_EM_RUN   = 4'h1;
	localparam logic [3:0]  EVPR_EM_SILENT = 4'h3;
	localparam logic [3:0]  EVPR_ET_MAX   = 4'h1;
	localparam logic [3:0]  EVPR_EM_MAX   = 4'h3;
	localparam logic [11:0] EVPR_GLOBAL   = 12'hffe;
	localparam logic [11:0] EVPR_NOBODY   = 12'hfff;
	// Register byte addresses
	localparam logic [7:0]  EVPR_R_CTRL   = 8'h00;
	localparam logic [7:0]  EVPR_R_FLAGS  = 8'h04;
	localparam logic [7:0]  EVPR_R_PCW_HI = 8'h08;
	localparam logic [7:0]  EVPR_R_PCW_LO = 8'h0c;
	localparam logic [7:0]  EVPR_R_PCW_SK = 8'h10;
	localparam logic [7:0]  EVPR_R_SRC_HI = 8'h14;
	localparam logic [7:0]  EVPR_R_SRC_LO = 8'h18;
	localparam logic [7:0]  EVPR_R_SINK   = 8'h1c;
	// Control register fields
	localparam int          EVPR_CTRL_EN  = 12;
	// Flags register fields
	localparam int          EVPR_FL_ANN   = 0;
	localparam int          EVPR_FL_CAN   = 2;
	localparam int          EVPR_FL_PAR   = 4;
	localparam int          EVPR_FL_NEW   = 6;
	localparam int          EVPR_FL_ET    = 7;
	localparam int          EVPR_FL_ETOK  = 8;
	// Port control word fields
	localparam int          EVPR_PC_SRC   = 0;
	localparam int          EVPR_PC_SINK  = 1;
	localparam int          EVPR_PC_TDIS  = 2;
	localparam int          EVPR_PC_CPE   = 3;
	localparam logic [11:0] EVPR_NODE_RST = 12'h000;
	typedef enum logic [1:0] {
		EVPR_IDLE = 2'b00,
		EVPR_WAIT = 2'b01
	} evpr_poll_t;
	typedef struct packed {
		evpr_poll_t  poll;
		logic        et;
		logic        et_ok;
		logic [1:0]  ann;
		logic [1:0]  par;
		logic        rx_en;
		logic [11:0] node;
		logic [4:0]  pcw_hi;
		logic [4:0]  pcw_lo;
		logic [4:0]  pcw_sink;
		logic [15:0] src_hi;
		logic [15:0] src_lo;
		logic [15:0] sink_data;
		logic        sink_new;
		logic        reply_valid;
		logic [15:0] reply_word;
		logic [31:0] rdata;
	} evpr_state_t;
endpackage

// [evpr_responder.sv]
// Event poll responder: group and individual event polls, flag upkeep.
// Assumes frames arrive decoded as one-cycle strobes on the mclk domain.
//
// Contract
// - Function code 13 is a group poll with a 12-bit group pattern.
// - Group pattern selects a bisected group of 2 up to 4096 devices.
// - Pattern all ones with low zero addresses every device.
// - Leading ones then zero form a prefix; bits below must match own address.
// - Top bit zero compares eleven address bits, selecting two devices.
// - Group poll replies from remembered type's source if matched and participating.
// - Function code 14 is an individual poll to one 12-bit address.
// - Individual poll replies only on own address and active participation.
// - Source port used only if active source, not disabled, reception enabled.
// - Sink captures poll reply only if active sink, not disabled, enabled.
// - Reply is one word; master tolerates collision or silence.
// - Any transmission of a port with clear-pending clears announce and participation.
// - Writing one to a cancel bit clears announce and participation.
// - Without clear-pending transmission the flags stay and participation continues.
// - Reception enable low suspends participation and replies.
// - Round-starting start poll sets participation where announced.
`timescale 1ns/100ps
module evpr_responder
	import evpr_pkg::*;
#(
	parameter int REG_AW = 8
) (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        mf_valid,
	input  wire logic [15:0] mf_word,
	input  wire logic        sf_valid,
	input  wire logic [15:0] sf_word,
	input  wire logic        port_tx_done,
	input  wire logic [1:0]  port_tx_cpe,
	input  wire logic [REG_AW-1:0] reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [31:0]      reg_rdata,
	output logic             reply_valid,
	output logic [15:0]      reply_word
);

	generate
		if (REG_AW < 5 || REG_AW > 8) begin : g_bad_aw
			$error("REG_AW must be 5 to 8");
		end
	endgenerate

	evpr_state_t s;
	evpr_state_t next_s;

	// Group pattern decode: highest-order zero, ending the leading ones run, marks the prefix
	function automatic logic group_match(input logic [11:0] pat, input logic [11:0] node);
		logic hit;
		logic done;
		hit = 1'b0;
		done = 1'b0;
		for (int i = EVPR_AW - 1; i >= 0; i--) begin
			if (!done && !pat[i]) begin
				done = 1'b1;
				hit = 1'b1;
				for (int j = 0; j < i; j++) begin
					if (pat[j] != node[j]) begin
						hit = 1'b0;
					end
				end
			end
		end
		return hit;
	endfunction

	function automatic logic src_ok(input logic [4:0] pcw);
		return pcw[EVPR_PC_SRC] && !pcw[EVPR_PC_TDIS];
	endfunction

	function automatic logic sink_ok(input logic [4:0] pcw);
		return pcw[EVPR_PC_SINK] && !pcw[EVPR_PC_TDIS];
	endfunction

	logic [3:0]  fcode;
	logic [3:0]  em_f;
	logic [3:0]  et_f;
	logic [11:0] addr_f;
	logic [7:0]  ra;
	logic [4:0]  cur_pcw;
	logic [15:0] cur_src;
	logic        addr_hit;
	logic        reply_now;
	logic [1:0]  clr;
	logic [1:0]  par_set;
	logic [1:0]  ann_set;

	assign fcode   = mf_word[EVPR_FC_LSB +: 4];
	assign em_f    = mf_word[EVPR_EM_LSB +: 4];
	assign et_f    = mf_word[EVPR_ET_LSB +: 4];
	assign addr_f  = mf_word[EVPR_AW-1:0];
	assign ra      = 8'(reg_addr);
	assign cur_pcw = s.et ? s.pcw_lo : s.pcw_hi;
	assign cur_src = s.et ? s.src_lo : s.src_hi;

	always_comb begin
		addr_hit = 1'b0;
		if (fcode == EVPR_FC_GROUP) begin
			addr_hit = group_match(addr_f, s.node);
		end else if (fcode == EVPR_FC_INDIV) begin
			addr_hit = addr_f == s.node;
		end
	end

	// Reply when matched, participating, source usable and reception on
	assign reply_now = mf_valid && addr_hit && s.et_ok && s.par[s.et] && s.rx_en
		&& src_ok(cur_pcw);

	always_comb begin
		next_s = s;
		next_s.reply_valid = 1'b0;
		clr = 2'b00;
		par_set = 2'b00;
		ann_set = 2'b00;
		// Reading the sink clears its new flag; a capture in the same cycle wins
		if (reg_rd && ra == EVPR_R_SINK) begin
			next_s.sink_new = 1'b0;
		end
		if (s.poll == EVPR_WAIT && sf_valid) begin
			next_s.sink_data = sf_word;
			next_s.sink_new = 1'b1;
			next_s.poll = EVPR_IDLE;
		end
		if (mf_valid) begin
			next_s.poll = EVPR_IDLE;
			case (fcode)
				EVPR_FC_START: begin
					if (et_f <= EVPR_ET_MAX && em_f <= EVPR_EM_MAX) begin
						next_s.et = et_f[0];
						next_s.et_ok = 1'b1;
						if (s.rx_en && (em_f == EVPR_EM_RUN || em_f == EVPR_EM_SILENT)) begin
							par_set[et_f[0]] = s.ann[et_f[0]];
						end
					end else begin
						next_s.et_ok = 1'b0;
					end
				end
				EVPR_FC_GROUP, EVPR_FC_INDIV: begin
					if (reply_now) begin
						next_s.reply_valid = 1'b1;
						next_s.reply_word = cur_src;
						clr = cur_pcw[EVPR_PC_CPE +: 2];
					end
					if (s.rx_en && sink_ok(s.pcw_sink)) begin
						next_s.poll = EVPR_WAIT;
					end
				end
				default: begin
					next_s.poll = EVPR_IDLE;
				end
			endcase
		end
		if (port_tx_done) begin
			clr = clr | port_tx_cpe;
		end
		// Register writes
		if (reg_wr) begin
			case (ra)
				EVPR_R_CTRL: begin
					next_s.node = reg_wdata[EVPR_AW-1:0];
					next_s.rx_en = reg_wdata[EVPR_CTRL_EN];
				end
				EVPR_R_FLAGS: begin
					ann_set = reg_wdata[EVPR_FL_ANN +: 2];
					clr = clr | reg_wdata[EVPR_FL_CAN +: 2];
				end
				EVPR_R_PCW_HI: begin
					next_s.pcw_hi = reg_wdata[4:0];
				end
				EVPR_R_PCW_LO: begin
					next_s.pcw_lo = reg_wdata[4:0];
				end
				EVPR_R_PCW_SK: begin
					next_s.pcw_sink = reg_wdata[4:0];
				end
				EVPR_R_SRC_HI: begin
					next_s.src_hi = reg_wdata[15:0];
				end
				EVPR_R_SRC_LO: begin
					next_s.src_lo = reg_wdata[15:0];
				end
				default: begin
					next_s.node = s.node;
				end
			endcase
		end
		// Clears first, sets after so a coincident set survives
		next_s.ann = (s.ann & ~clr) | ann_set;
		next_s.par = (s.par & ~clr) | par_set;
		// Register reads, answered in the next cycle
		next_s.rdata = 32'h0;
		if (reg_rd) begin
			case (ra)
				EVPR_R_CTRL: next_s.rdata = {19'h0, s.rx_en, s.node};
				EVPR_R_FLAGS: next_s.rdata = {23'h0, s.et_ok, s.et, s.sink_new, s.par, 2'h0, s.ann};
				EVPR_R_PCW_HI: next_s.rdata = {27'h0, s.pcw_hi};
				EVPR_R_PCW_LO: next_s.rdata = {27'h0, s.pcw_lo};
				EVPR_R_PCW_SK: next_s.rdata = {27'h0, s.pcw_sink};
				EVPR_R_SRC_HI: next_s.rdata = {16'h0, s.src_hi};
				EVPR_R_SRC_LO: next_s.rdata = {16'h0, s.src_lo};
				EVPR_R_SINK: next_s.rdata = {16'h0, s.sink_data};
				default: next_s.rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			s <= '0;
			s.node <= EVPR_NODE_RST;
			s.poll <= EVPR_IDLE;
		end else begin
			s <= next_s;
		end
	end

	assign reg_rdata   = s.rdata;
	assign reply_valid = s.reply_valid;
	assign reply_word  = s.reply_word;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	logic [3:0] st_fc;
	assign st_fc = mf_word[EVPR_FC_LSB +: 4];

	a_no_rx_reply: assert property (mf_valid && !s.rx_en |=> !reply_valid)
		else $error("Reply sent with reception disabled");
	a_global_hit: assert property (mf_valid && st_fc == EVPR_FC_GROUP
		&& addr_f == EVPR_GLOBAL && s.et_ok && s.par[s.et] && s.rx_en
		&& src_ok(cur_pcw) |=> reply_valid)
		else $error("Global poll not answered");
	a_all_ones: assert property (mf_valid && st_fc == EVPR_FC_GROUP
		&& addr_f == EVPR_NOBODY |=> !reply_valid)
		else $error("All-ones pattern answered");
	a_half_group: assert property (mf_valid && st_fc == EVPR_FC_GROUP
		&& addr_f[11:1] == {EVPR_GLOBAL[11:2], 1'b0} && addr_f[0] != s.node[0]
		|=> !reply_valid)
		else $error("Half group answered on wrong low bit");
	a_pair_group: assert property (mf_valid && st_fc == EVPR_FC_GROUP
		&& !addr_f[11] && addr_f[10:0] != s.node[10:0] |=> !reply_valid)
		else $error("Two-device group answered on mismatch");
	a_indiv_miss: assert property (mf_valid && st_fc == EVPR_FC_INDIV
		&& addr_f != s.node |=> !reply_valid)
		else $error("Individual poll answered for other address");
	a_reply_cause: assert property (reply_valid |-> $past(mf_valid)
		&& $past(s.par[s.et]) && $past(src_ok(cur_pcw)) && reply_word == $past(cur_src))
		else $error("Reply without valid cause or wrong word");
	a_single_word: assert property (reply_valid && !mf_valid |=> !reply_valid)
		else $error("Reply longer than one word");
	a_start_par: assert property (mf_valid && st_fc == EVPR_FC_START
		&& em_f == EVPR_EM_RUN && et_f == 4'h0 && s.rx_en && s.ann[0]
		|=> s.par[0] && s.et == 1'b0 && s.et_ok)
		else $error("Start poll did not set participation");
	a_silent_par: assert property (mf_valid && st_fc == EVPR_FC_START
		&& em_f == EVPR_EM_SILENT && et_f == 4'h1 && s.rx_en && s.ann[1]
		|=> s.par[1] && s.et && s.et_ok)
		else $error("Silent start poll did not set participation");
	a_start_no_rx: assert property (mf_valid && st_fc == EVPR_FC_START
		&& !s.rx_en |=> (s.par & ~$past(s.par)) == 2'b00)
		else $error("Participation gained with reception disabled");
	a_reply_rx: assert property (reply_valid |-> $past(s.rx_en))
		else $error("Reply follows a cycle with reception disabled");
	a_bad_type: assert property (mf_valid && st_fc == EVPR_FC_START
		&& et_f > EVPR_ET_MAX |=> !s.et_ok)
		else $error("Illegal event type left type memory valid");
	a_et_hold: assert property (!(mf_valid && st_fc == EVPR_FC_START)
		|=> $stable(s.et))
		else $error("Remembered type changed without start poll");
	a_cancel_hi: assert property (reg_wr && ra == EVPR_R_FLAGS
		&& reg_wdata[EVPR_FL_CAN] && !reg_wdata[EVPR_FL_ANN] && !mf_valid
		|=> !s.ann[0] && !s.par[0])
		else $error("Cancel did not clear flags");
	a_cancel_lo: assert property (reg_wr && ra == EVPR_R_FLAGS
		&& reg_wdata[EVPR_FL_CAN + 1] && !reg_wdata[EVPR_FL_ANN + 1] && !mf_valid
		|=> !s.ann[1] && !s.par[1])
		else $error("Low cancel did not clear flags");
	a_cpe_clear: assert property (port_tx_done && port_tx_cpe[1]
		&& !reg_wr && !mf_valid |=> !s.ann[1] && !s.par[1])
		else $error("Clear-pending transmission left flags set");
	a_cpe_hi: assert property (port_tx_done && port_tx_cpe[0]
		&& !reg_wr && !mf_valid |=> !s.ann[0] && !s.par[0])
		else $error("High clear-pending transmission left flags set");
	a_keep_flags: assert property (!port_tx_done && !mf_valid && !reg_wr
		|=> s.ann == $past(s.ann) && s.par == $past(s.par))
		else $error("Flags changed without cause");
	a_sink_take: assert property (s.poll == EVPR_WAIT && sf_valid
		|=> s.sink_data == $past(sf_word) && s.sink_new)
		else $error("Sink missed poll reply");

	c_group_reply: cover property (mf_valid && st_fc == EVPR_FC_GROUP ##1 reply_valid);
	c_indiv_reply: cover property (mf_valid && st_fc == EVPR_FC_INDIV ##1 reply_valid);
	c_sink_take: cover property (s.poll == EVPR_WAIT && sf_valid);
	c_cancel: cover property (reg_wr && ra == EVPR_R_FLAGS && |reg_wdata[EVPR_FL_CAN +: 2]);
	c_cpe_clear: cover property (port_tx_done && |port_tx_cpe);

endmodule

// [evpr_master_model.sv]
// Bus administrator master model: issues master frames, echoes replies as slave frames.
// Assumes the bench requests one master frame by raising go for one cycle.
`timescale 1ns/100ps
module evpr_master_model (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        go,
	input  wire logic [15:0] go_word,
	input  wire logic        reply_valid,
	input  wire logic [15:0] reply_word,
	output logic             mf_valid,
	output logic [15:0]      mf_word,
	output logic             sf_valid,
	output logic [15:0]      sf_word
);
	logic [15:0] last;
	always_ff @(posedge mclk) begin
		if (rst) begin
			last     <= 16'h0000;
			sf_valid <= 1'b0;
			sf_word  <= 16'h0000;
		end else begin
			if (go) begin
				last <= go_word;
			end
			sf_valid <= reply_valid;
			sf_word  <= reply_valid ? reply_word : ~sf_word;
		end
	end
	// Released bus shows the inverse of the last frame
	assign mf_valid = go;
	assign mf_word  = go ? go_word : ~last;
endmodule

// [test_evpr_responder.sv]
// Testbench for the event poll responder, driving polls through the master model.
// Assumes a 200 MHz clock and the register map of the package.
`timescale 1ns/100ps
module test_evpr_responder;
	import evpr_pkg::*;
	logic        mclk         = 1'b0;
	logic        rst          = 1'b1;
	logic        go           = 1'b0;
	logic [15:0] go_word      = 16'h0000;
	logic        port_tx_done = 1'b0;
	logic [1:0]  port_tx_cpe  = 2'h0;
	logic [7:0]  reg_addr     = 8'h00;
	logic [31:0] reg_wdata    = 32'h0;
	logic        reg_wr       = 1'b0;
	logic        reg_rd       = 1'b0;
	logic [31:0] reg_rdata;
	logic        reply_valid;
	logic        mf_valid;
	logic        sf_valid;
	logic [15:0] reply_word;
	logic [15:0] mf_word;
	logic [15:0] sf_word;
	int          failures     = 0;
	int          total_checks = 0;
	always #2.5 mclk = ~mclk;
	evpr_responder DUT (.mclk(mclk), .rst(rst), .mf_valid(mf_valid), .mf_word(mf_word),
		.sf_valid(sf_valid), .sf_word(sf_word), .port_tx_done(port_tx_done),
		.port_tx_cpe(port_tx_cpe), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.reply_valid(reply_valid), .reply_word(reply_word));
	evpr_master_model master (.mclk(mclk), .rst(rst), .go(go), .go_word(go_word),
		.reply_valid(reply_valid), .reply_word(reply_word), .mf_valid(mf_valid),
		.mf_word(mf_word), .sf_valid(sf_valid), .sf_word(sf_word));
	task automatic give_verdict();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge mclk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		check(reg_rdata, exp);
	endtask
	// Expected value: bit 16 reply seen, low half the reply word
	task automatic poll(input logic [15:0] w, input logic [31:0] exp);
		@(posedge mclk);
		go      <= 1'b1;
		go_word <= w;
		@(posedge mclk);
		go <= 1'b0;
		#1;
		check({15'h0, reply_valid, reply_valid === 1'b1 ? reply_word : 16'h0}, exp);
		repeat (2) @(posedge mclk);
	endtask
	task automatic tx(input logic [1:0] c);
		@(posedge mclk);
		port_tx_done <= 1'b1;
		port_tx_cpe  <= c;
		@(posedge mclk);
		port_tx_done <= 1'b0;
	endtask
	task automatic sc_setup();
		wr(EVPR_R_CTRL, 32'h15a3);
		wr(EVPR_R_PCW_HI, 32'h1);
		wr(EVPR_R_PCW_LO, 32'h1);
		wr(EVPR_R_PCW_SK, 32'h2);
		wr(EVPR_R_SRC_HI, 32'hc5a3);
		wr(EVPR_R_SRC_LO, 32'hc123);
		wr(EVPR_R_FLAGS, 32'h3);
		poll(16'h9100, 32'h0);
		rd(EVPR_R_FLAGS, 32'h113);
	endtask
	task automatic sc_groups();
		logic [15:0] w [11];
		logic [31:0] e [11];
		w = '{16'hdffe, 16'hdffd, 16'hdffc, 16'hdffb, 16'hd9a3, 16'hd5a3, 16'hd5a2,
			16'hd7a3, 16'hdfff, 16'he5a3, 16'he5a4};
		e = '{32'h1c5a3, 32'h1c5a3, 32'h0, 32'h1c5a3, 32'h1c5a3, 32'h1c5a3, 32'h0,
			32'h0, 32'h0, 32'h1c5a3, 32'h0};
		for (int i = 0; i < 11; i++) begin
			poll(w[i], e[i]);
		end
		poll(16'hc5a3, 32'h0);
	endtask
	task automatic sc_sink();
		rd(EVPR_R_FLAGS, 32'h153);
		rd(EVPR_R_SINK, 32'hc5a3);
		rd(EVPR_R_FLAGS, 32'h113);
	endtask
	task automatic sc_gating();
		wr(EVPR_R_PCW_HI, 32'h5);
		poll(16'hdffe, 32'h0);
		wr(EVPR_R_PCW_HI, 32'h1);
		wr(EVPR_R_CTRL, 32'h05a3);
		poll(16'he5a3, 32'h0);
		poll(16'h9100, 32'h0);
		wr(EVPR_R_CTRL, 32'h15a3);
	endtask
	task automatic sc_clear();
		tx(2'h0);
		poll(16'hdffe, 32'h1c5a3);
		rd(EVPR_R_FLAGS, 32'h153);
		tx(2'h1);
		rd(EVPR_R_FLAGS, 32'h142);
		poll(16'hdffe, 32'h0);
	endtask
	task automatic sc_type();
		poll(16'h9110, 32'h0);
		rd(EVPR_R_FLAGS, 32'h1e2);
		poll(16'hdffe, 32'h1c123);
		wr(EVPR_R_PCW_LO, 32'h11);
		poll(16'he5a3, 32'h1c123);
		rd(EVPR_R_FLAGS, 32'h1c0);
		wr(EVPR_R_PCW_LO, 32'h1);
		wr(EVPR_R_FLAGS, 32'h2);
		poll(16'h9110, 32'h0);
		wr(EVPR_R_FLAGS, 32'h8);
		rd(EVPR_R_FLAGS, 32'h1c0);
		wr(EVPR_R_FLAGS, 32'h1);
		wr(EVPR_R_FLAGS, 32'h4);
		rd(EVPR_R_FLAGS, 32'h1c0);
		wr(EVPR_R_FLAGS, 32'h2);
		poll(16'h9310, 32'h0);
		rd(EVPR_R_FLAGS, 32'h1e2);
		tx(2'h2);
		rd(EVPR_R_FLAGS, 32'h1c0);
		poll(16'h9220, 32'h0);
		rd(EVPR_R_FLAGS, 32'h0c0);
		rd(8'h20, 32'h0);
	endtask
	initial begin
		#100000;
		failures++;
		give_verdict();
	end
	initial begin
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		sc_setup();
		sc_groups();
		sc_sink();
		sc_gating();
		sc_clear();
		sc_type();
		give_verdict();
	end
endmodule
